// File: core/mgp_device.sv
// switch controller manager port, reset chain, memory command bus and cbr pacing
// assumes the host keeps strobe phases and data stable for PHASE_CYCLES clocks,
// and that the switching memory runs on the same system clock
`timescale 1ns/1ps

module mgp_device (
    input  wire logic                clk,
    input  wire logic                reset,
    mgp_if.dev                       mgr,
    input  wire logic                reset_in,
    output logic                     reset_chain_out,
    input  wire logic                const_rate_clock_hi,
    input  wire logic                const_rate_clock_lo,
    input  wire logic                header_check_error_n,
    output logic [5:0]               memory_command_bus,
    output logic [31:0]              control_data_out,
    output logic [31:0]              control_data_oe,
    output logic                     cbr_slot_valid,
    output logic [1:0]               cbr_slot_priority,
    output logic                     header_error
);
    import mgp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // reset: asserts at once from either source, releases on the clock

    logic       raw_rst;
    logic [1:0] rst_q;
    logic       int_rst;

    assign raw_rst = reset | reset_in;

    always_ff @(posedge clk or posedge raw_rst)
    begin
        if (raw_rst)
            rst_q <= 2'h3;
        else
            rst_q <= {rst_q[0], 1'b0};
    end

    assign int_rst = rst_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [9:0] bus_lvl;
    logic [2:0] ev_lvl;
    logic [2:0] ev_rise;
    logic       sel_s;
    logic       rw_s;
    logic [7:0] din_s;

    mgp_edge_sync #(.WIDTH(10)) u_bus_sync (
        .clk   (clk),
        .reset (int_rst),
        .pin   ({mgr.host_reg_group_select, mgr.host_read_write_select, mgr.host_data_bus}),
        .level (bus_lvl),
        .rise  ()
    );

    mgp_edge_sync #(.WIDTH(3)) u_ev_sync (
        .clk   (clk),
        .reset (int_rst),
        .pin   ({mgr.host_strobe, const_rate_clock_hi, const_rate_clock_lo}),
        .level (ev_lvl),
        .rise  (ev_rise)
    );

    assign sel_s = bus_lvl[9];
    assign rw_s  = bus_lvl[8];
    assign din_s = bus_lvl[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // write decode

    logic wr_ev;
    logic data_wr;
    logic cmd_wr;
    logic start_wr;
    logic clr_err_wr;
    logic mem_wr;

    // strobe edge seen two clocks late; host holds data past it
    assign wr_ev      = ev_rise[2] & ~rw_s;
    assign data_wr    = wr_ev & sel_s;
    assign cmd_wr     = wr_ev & ~sel_s;
    assign start_wr   = cmd_wr & (din_s == CMD_START);
    assign clr_err_wr = cmd_wr & (din_s == CMD_CLR_HDR_ERR);
    assign mem_wr     = cmd_wr & din_s[CMD_MEM_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // reset chain output

    logic reset_chain_q;

    always_ff @(posedge clk or posedge raw_rst)
    begin
        if (raw_rst)
            reset_chain_q <= 1'b1;
        else if (start_wr)
            reset_chain_q <= 1'b0;
    end

    assign reset_chain_out = reset_chain_q;

    ////////////////////////////////////////////////////////////////////////////
    // data group: four bytes build the control word, first byte ends up on top

    logic [31:0] data_word_q;
    logic [1:0]  byte_cnt_q;

    always_ff @(posedge clk or posedge int_rst)
    begin
        if (int_rst)
        begin
            data_word_q <= WORD_RESET;
            byte_cnt_q  <= 2'h0;
        end
        else if (data_wr)
        begin
            data_word_q <= {data_word_q[23:0], din_s};
            byte_cnt_q  <= byte_cnt_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory command bus and control data stage

    logic [5:0] mem_cmd_q;
    logic       cdb_stage_q;
    logic       store_stage_q;
    logic [31:0] cdb_out_q;

    always_ff @(posedge clk or posedge int_rst)
    begin
        if (int_rst)
            mem_cmd_q <= MEM_NOP;
        else if (mem_wr)
            mem_cmd_q <= din_s[5:0];
        else
            mem_cmd_q <= MEM_NOP;
    end

    // control word follows its command by exactly one clock
    always_ff @(posedge clk or posedge int_rst)
    begin
        if (int_rst)
        begin
            cdb_stage_q   <= 1'b0;
            store_stage_q <= 1'b0;
            cdb_out_q     <= WORD_RESET;
        end
        else
        begin
            cdb_stage_q   <= (mem_cmd_q != MEM_NOP);
            store_stage_q <= (mem_cmd_q == MEM_STORE);
            cdb_out_q     <= data_word_q;
        end
    end

    assign memory_command_bus = mem_cmd_q;
    assign control_data_out   = cdb_out_q;
    assign control_data_oe    = {32{cdb_stage_q}};

    ////////////////////////////////////////////////////////////////////////////
    // header error: sampled directly, the memory shares this clock

    logic store_window;
    logic hdr_err_q;

    assign store_window = (mem_cmd_q == MEM_STORE) | store_stage_q;

    always_ff @(posedge clk or posedge int_rst)
    begin
        if (int_rst)
            hdr_err_q <= 1'b0;
        else if (store_window & ~header_check_error_n)
            hdr_err_q <= 1'b1;
        else if (clr_err_wr)
            hdr_err_q <= 1'b0;
    end

    assign header_error = hdr_err_q;

    ////////////////////////////////////////////////////////////////////////////
    // cbr pacing: one pending slot per level, high level always first

    logic hi_pend_q;
    logic lo_pend_q;
    logic grant_hi;
    logic grant_lo;
    logic slot_vld_q;
    logic [1:0] slot_prio_q;

    assign grant_hi = hi_pend_q;
    assign grant_lo = lo_pend_q & ~hi_pend_q;

    // an edge in the grant cycle re-arms the slot, so no tick is lost
    always_ff @(posedge clk or posedge int_rst)
    begin
        if (int_rst)
        begin
            hi_pend_q <= 1'b0;
            lo_pend_q <= 1'b0;
        end
        else
        begin
            hi_pend_q <= ev_rise[1] | (hi_pend_q & ~grant_hi);
            lo_pend_q <= ev_rise[0] | (lo_pend_q & ~grant_lo);
        end
    end

    always_ff @(posedge clk or posedge int_rst)
    begin
        if (int_rst)
        begin
            slot_vld_q  <= 1'b0;
            slot_prio_q <= PRIO_LO;
        end
        else
        begin
            slot_vld_q  <= grant_hi | grant_lo;
            slot_prio_q <= grant_hi ? PRIO_HI : PRIO_LO;
        end
    end

    assign cbr_slot_valid    = slot_vld_q;
    assign cbr_slot_priority = slot_prio_q;

    ////////////////////////////////////////////////////////////////////////////
    // read path: data registered, enable straight from the pins

    logic [7:0] status;
    logic [7:0] rd_q;

    always_comb
    begin
        status = 8'h00;
        status[ST_RESET_OUT] = reset_chain_q;
        status[ST_HDR_ERR]   = hdr_err_q;
        status[ST_CBR_HI]    = hi_pend_q;
        status[ST_CBR_LO]    = lo_pend_q;
        status[ST_BYTE_LSB +: 2] = byte_cnt_q;
    end

    always_ff @(posedge clk or posedge int_rst)
    begin
        if (int_rst)
            rd_q <= RD_RESET;
        else
            rd_q <= sel_s ? data_word_q[7:0] : status;
    end

    // enable must not wait for a clock edge
    assign mgr.dev_out = rd_q;
    assign mgr.dev_oe  = ~mgr.host_strobe & mgr.host_read_write_select;
endmodule // mgp_device

// File: include/mgp_pkg.sv
// constants shared by both ends of the manager port and by the device core
// assumes both ends run on one 125 MHz system clock
package mgp_pkg;

    localparam int CLK_PERIOD_NS = 8;
    localparam int SYNC_STAGES   = 2;

    // strobe phases made by the host divider, in system clock cycles;
    // each must cover the device's two-stage synchroniser plus edge detect
    localparam int PHASE_NS      = 32;
    localparam int PHASE_CYCLES  = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // command/status group bytes
    localparam logic [7:0] CMD_START       = 8'h01;
    localparam logic [7:0] CMD_CLR_HDR_ERR = 8'h02;
    localparam int         CMD_MEM_BIT     = 7;

    // switching memory command codes
    localparam logic [5:0] MEM_NOP   = 6'h00;
    localparam logic [5:0] MEM_STORE = 6'h01;

    // status byte fields
    localparam int ST_RESET_OUT = 7;
    localparam int ST_HDR_ERR   = 6;
    localparam int ST_CBR_HI    = 5;
    localparam int ST_CBR_LO    = 4;
    localparam int ST_BYTE_LSB  = 2;

    localparam logic [7:0]  RD_RESET   = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [7:0]  BUS_IDLE   = 8'hff;

    localparam logic [1:0] PRIO_HI = 2'h3;
    localparam logic [1:0] PRIO_LO = 2'h2;

endpackage

// File: include/mgp_if.sv
// manager bus between the call setup host and the switch controller
// assumes the bench joins the two modports; the shared data wire is resolved here
`timescale 1ns/1ps
interface mgp_if;
    import mgp_pkg::*;

    logic       host_reg_group_select;
    logic       host_read_write_select;
    logic       host_strobe;
    logic [7:0] host_out;
    logic       host_oe;
    logic [7:0] dev_out;
    logic       dev_oe;
    logic [7:0] host_data_bus;

    // pulled-up wire: the device wins while it drives, then the host while it drives
    always_comb
    begin
        if (dev_oe)
            host_data_bus = dev_out;
        else if (host_oe)
            host_data_bus = host_out;
        else
            host_data_bus = BUS_IDLE;
    end

    modport dev (
        input  host_reg_group_select,
        input  host_read_write_select,
        input  host_strobe,
        input  host_data_bus,
        output dev_out,
        output dev_oe
    );

    modport host (
        output host_reg_group_select,
        output host_read_write_select,
        output host_strobe,
        output host_out,
        output host_oe,
        input  host_data_bus
    );
endinterface

// File: core/mgp_edge_sync.sv
// two-flop synchroniser with rising edge pulse for a bundle of pins
// assumes pins are quasi-static relative to the sampling clock
`timescale 1ns/1ps
module mgp_edge_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);
    import mgp_pkg::*;

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stab_q;
    logic [WIDTH-1:0] last_q;
    logic [2:0]       arm_q;

    initial
    begin
        if (WIDTH < 1)
            $error("mgp_edge_sync: WIDTH must be at least 1");
    end

    // meta_q feeds stab_q only
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= '0;
            stab_q <= '0;
            last_q <= '0;
        end
        else
        begin
            meta_q <= pin;
            stab_q <= meta_q;
            last_q <= stab_q;
        end
    end

    // last_q is still cleared at the first compare after reset; a pin idling
    // high would fake an edge, so rise waits until last_q holds a real sample
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            arm_q <= 3'h0;
        else
            arm_q <= {arm_q[1:0], 1'b1};
    end

    assign level = stab_q;
    assign rise  = stab_q & ~last_q & {WIDTH{arm_q[2]}};
endmodule // mgp_edge_sync

// File: core/mgp_host.sv
// call setup host end of the manager bus: one byte access per request
// assumes the device samples pins through two-flop synchronisers
`timescale 1ns/1ps
module mgp_host (
    input  wire logic       clk,
    input  wire logic       reset,
    mgp_if.host             mgr,
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic       req_write,
    input  wire logic       req_group,
    input  wire logic [7:0] req_wdata,
    output logic            rsp_valid,
    output logic [7:0]      rsp_rdata
);
    import mgp_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HOLD} mgp_state_e;

    localparam logic [3:0] PHASE_LAST = 4'(PHASE_CYCLES - 1);

    mgp_state_e state_q;
    logic [3:0] cnt_q;
    logic       write_q;
    logic       group_q;
    logic [7:0] wdata_q;
    logic       strobe_q;
    logic       rsp_vld_q;
    logic [7:0] rsp_q;
    logic [7:0] rd_s;
    logic       phase_end;

    initial
    begin
        if (PHASE_CYCLES < 4 || PHASE_CYCLES > 16)
            $error("mgp_host: PHASE_CYCLES must be 4..16");
    end

    // read data comes back across the pins
    mgp_edge_sync #(.WIDTH(8)) u_rd_sync (
        .clk   (clk),
        .reset (reset),
        .pin   (mgr.host_data_bus),
        .level (rd_s),
        .rise  ()
    );

    assign phase_end = (cnt_q == PHASE_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // strobe divider: setup high, strobe low, hold high

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q  <= ST_IDLE;
            cnt_q    <= 4'h0;
            strobe_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= 4'h0;
                    if (req_valid)
                        state_q <= ST_SETUP;
                end
                ST_SETUP:
                begin
                    cnt_q <= phase_end ? 4'h0 : cnt_q + 4'h1;
                    if (phase_end)
                    begin
                        state_q  <= ST_LOW;
                        strobe_q <= 1'b0;
                    end
                end
                ST_LOW:
                begin
                    cnt_q <= phase_end ? 4'h0 : cnt_q + 4'h1;
                    if (phase_end)
                    begin
                        state_q  <= ST_HOLD;
                        strobe_q <= 1'b1;
                    end
                end
                ST_HOLD:
                begin
                    cnt_q <= phase_end ? 4'h0 : cnt_q + 4'h1;
                    if (phase_end)
                        state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q  <= ST_IDLE;
                    strobe_q <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            write_q <= 1'b0;
            group_q <= 1'b0;
            wdata_q <= 8'h00;
        end
        else if (state_q == ST_IDLE && req_valid)
        begin
            write_q <= req_write;
            group_q <= req_group;
            wdata_q <= req_wdata;
        end
    end

    // sampled at the end of the low phase, after the two-flop delay
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rsp_vld_q <= 1'b0;
            rsp_q     <= 8'h00;
        end
        else
        begin
            rsp_vld_q <= (state_q == ST_LOW) && phase_end && !write_q;
            if ((state_q == ST_LOW) && phase_end && !write_q)
                rsp_q <= rd_s;
        end
    end

    assign req_ready = (state_q == ST_IDLE);
    assign rsp_valid = rsp_vld_q;
    assign rsp_rdata = rsp_q;

    // idle bus parks in read direction, released, strobe high
    assign mgr.host_strobe            = strobe_q;
    assign mgr.host_reg_group_select  = group_q;
    assign mgr.host_read_write_select = (state_q == ST_IDLE) | ~write_q;
    assign mgr.host_out               = wdata_q;
    assign mgr.host_oe                = (state_q != ST_IDLE) & write_q;
endmodule // mgp_host

// File: test/mgp_assertions.sv
// concurrent checks on the manager bus and the device's clocked pins
// assumes one clk domain; device reset is reset or reset_in
`timescale 1ns/1ps
module mgp_assertions
    import mgp_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        reset_in,
    input wire logic        host_reg_group_select,
    input wire logic        host_read_write_select,
    input wire logic        host_strobe,
    input wire logic [7:0]  host_out,
    input wire logic        host_oe,
    input wire logic [7:0]  dev_out,
    input wire logic        dev_oe,
    input wire logic [7:0]  host_data_bus,
    input wire logic        reset_chain_out,
    input wire logic        const_rate_clock_hi,
    input wire logic        const_rate_clock_lo,
    input wire logic        header_check_error_n,
    input wire logic [5:0]  memory_command_bus,
    input wire logic [31:0] control_data_oe,
    input wire logic        cbr_slot_valid,
    input wire logic [1:0]  cbr_slot_priority,
    input wire logic        header_error
);
    ////////////////////////////////////////////////////////////////////////////////
    read_enable_a: assert property (@(posedge clk) disable iff (reset || reset_in)
        !host_strobe && host_read_write_select |-> host_data_bus == dev_out) else $error("read data not on bus");
    no_contention_a: assert property (@(posedge clk) disable iff (reset || reset_in)
        !(dev_oe && host_oe)) else $error("both ends drive the data bus");
    read_bus_a: assert property (@(posedge clk) disable iff (reset || reset_in)
        !(!host_strobe && host_read_write_select) && !host_oe |-> host_data_bus == BUS_IDLE)
        else $error("device drives bus outside a read");
    // data must not move while the strobe is low or at its rising edge
    write_hold_a: assert property (@(posedge clk) disable iff (reset || reset_in)
        !host_read_write_select && host_oe && (!host_strobe || $rose(host_strobe))
        |-> $stable(host_out) && $stable(host_reg_group_select)) else $error("write data moved");
    cmd_pulse_a: assert property (@(posedge clk) disable iff (reset || reset_in)
        memory_command_bus != MEM_NOP |=> memory_command_bus == MEM_NOP && control_data_oe == 32'hffffffff)
        else $error("command not followed by control data");
    data_cause_a: assert property (@(posedge clk) disable iff (reset || reset_in)
        control_data_oe != 32'h0 |-> $past(memory_command_bus) != MEM_NOP) else $error("control data without command");
    hdr_set_a: assert property (@(posedge clk) disable iff (reset || reset_in)
        memory_command_bus == MEM_STORE && !header_check_error_n |=> header_error) else $error("header error missed");
    hdr_cause_a: assert property (@(posedge clk) disable iff (reset || reset_in)
        $rose(header_error) |-> !$past(header_check_error_n)) else $error("header error without cause");
    // checked during reset_in itself, so only the bench reset disables it
    reset_out_a: assert property (@(posedge clk) disable iff (reset)
        reset_in |-> reset_chain_out) else $error("reset output low during reset input");
    cbr_hi_a: assert property (@(posedge clk) disable iff (reset || reset_in)
        $rose(const_rate_clock_hi) |-> ##[2:6] (cbr_slot_valid && cbr_slot_priority == PRIO_HI))
        else $error("high cbr slot missing");
    cbr_lo_a: assert property (@(posedge clk) disable iff (reset || reset_in)
        $rose(const_rate_clock_lo) |-> ##[2:7] (cbr_slot_valid && cbr_slot_priority == PRIO_LO))
        else $error("low cbr slot missing");
endmodule // mgp_assertions

// File: test/test_manager_port_reset_and_command_pins.sv
// bench joining host and device ends over the manager bus interface
// assumes PHASE_CYCLES from the package; link clocks made here at 80 ns
`timescale 1ns/1ps
module test_manager_port_reset_and_command_pins;
    import mgp_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        reset_in = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic        req_group = 1'b0;
    logic [7:0]  req_wdata = 8'h00;
    logic        req_ready;
    logic        rsp_valid;
    logic [7:0]  rsp_rdata;
    logic        reset_chain_out;
    logic        const_rate_clock_hi = 1'b0;
    logic        const_rate_clock_lo = 1'b0;
    logic        header_check_error_n = 1'b1;
    logic [5:0]  memory_command_bus;
    logic [31:0] control_data_out;
    logic [31:0] control_data_oe;
    logic        cbr_slot_valid;
    logic [1:0]  cbr_slot_priority;
    logic        header_error;
    logic [5:0]  last_cmd = 6'h00;
    logic [31:0] last_word = 32'h0;
    logic        prev_hi = 1'b0;
    int          err_total = 0;
    int          checks = 0;
    int          cycles = 0;
    int          hi_cnt = 0;
    int          lo_cnt = 0;
    int          order_bad = 0;

    mgp_if mgp_if_inst ();
    mgp_host mgp_host_inst (.clk(clk), .reset(reset), .mgr(mgp_if_inst.host), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_group(req_group), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    mgp_device mgp_device_inst (.clk(clk), .reset(reset), .mgr(mgp_if_inst.dev), .reset_in(reset_in),
        .reset_chain_out(reset_chain_out), .const_rate_clock_hi(const_rate_clock_hi),
        .const_rate_clock_lo(const_rate_clock_lo), .header_check_error_n(header_check_error_n),
        .memory_command_bus(memory_command_bus), .control_data_out(control_data_out),
        .control_data_oe(control_data_oe), .cbr_slot_valid(cbr_slot_valid),
        .cbr_slot_priority(cbr_slot_priority), .header_error(header_error));
    mgp_assertions mgp_assertions_inst (.clk(clk), .reset(reset), .reset_in(reset_in),
        .host_reg_group_select(mgp_if_inst.host_reg_group_select),
        .host_read_write_select(mgp_if_inst.host_read_write_select), .host_strobe(mgp_if_inst.host_strobe),
        .host_out(mgp_if_inst.host_out), .host_oe(mgp_if_inst.host_oe), .dev_out(mgp_if_inst.dev_out),
        .dev_oe(mgp_if_inst.dev_oe), .host_data_bus(mgp_if_inst.host_data_bus),
        .reset_chain_out(reset_chain_out), .const_rate_clock_hi(const_rate_clock_hi),
        .const_rate_clock_lo(const_rate_clock_lo), .header_check_error_n(header_check_error_n),
        .memory_command_bus(memory_command_bus), .control_data_oe(control_data_oe),
        .cbr_slot_valid(cbr_slot_valid), .cbr_slot_priority(cbr_slot_priority), .header_error(header_error));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #4 clk = ~clk;
    end

    // command pulses are gone before an access returns; control data stays on the bus one clock longer
    always @(posedge clk)
    begin
        cycles++;
        if (cbr_slot_valid === 1'b1 && cbr_slot_priority === PRIO_HI)
            hi_cnt++;
        if (cbr_slot_valid === 1'b1 && cbr_slot_priority === PRIO_LO)
        begin
            lo_cnt++;
            if (!prev_hi)
                order_bad++;
        end
        prev_hi = (cbr_slot_valid === 1'b1 && cbr_slot_priority === PRIO_HI);
        if (memory_command_bus !== MEM_NOP)
            last_cmd = memory_command_bus;
        if (control_data_oe === 32'hffffffff)
            last_word = control_data_out;
        if (cycles == 5000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic access(input logic wr, input logic grp, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        rd = 8'h00;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_group <= grp;
        req_wdata <= wd;
        @(posedge clk);
        req_valid <= 1'b0;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk);
            #1;
            if (rsp_valid === 1'b1)
                rd = rsp_rdata;
            if (req_ready === 1'b1)
                break;
        end
        if (n == 40)
            err_total++;
    endtask

    task automatic write_byte(input logic grp, input logic [7:0] wd);
        logic [7:0] unused;
        access(1'b1, grp, wd, unused);
        repeat (4) @(posedge clk);
    endtask

    task automatic read_byte(input logic grp, input logic [7:0] exp, input string name);
        logic [7:0] rd;
        access(1'b0, grp, 8'h00, rd);
        check(name, {24'h0, rd}, {24'h0, exp});
    endtask

    task report_and_stop;
        if (err_total == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int i;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        check("reset out", reset_chain_out, 1);
        read_byte(1'b0, 8'h80, "status after reset");
        read_byte(1'b1, 8'h00, "data after reset");
        for (i = 0; i < 4; i++)
            write_byte(1'b1, 8'(8'h11 * (i + 1)));
        read_byte(1'b0, 8'h80, "count wrapped");
        write_byte(1'b1, 8'h55);
        read_byte(1'b1, 8'h55, "data low byte");
        read_byte(1'b1, 8'h55, "read does not store");
        read_byte(1'b0, 8'h84, "status count");
        write_byte(1'b0, 8'h81);
        check("store code", last_cmd, MEM_STORE);
        check("control word", last_word, 32'h22334455);
        check("no header error", header_error, 0);
        header_check_error_n <= 1'b0;
        write_byte(1'b0, 8'h81);
        header_check_error_n <= 1'b1;
        check("header error", header_error, 1);
        read_byte(1'b0, 8'hc4, "status error");
        write_byte(1'b0, 8'hbf);
        check("wide code", last_cmd, 6'h3f);
        check("error sticky", header_error, 1);
        write_byte(1'b0, CMD_CLR_HDR_ERR);
        check("error cleared", header_error, 0);
        write_byte(1'b0, 8'h05);
        check("unknown ignored", reset_chain_out, 1);
        write_byte(1'b0, CMD_START);
        check("released by start", reset_chain_out, 0);
        read_byte(1'b0, 8'h04, "status started");
        // both link clocks rise together, 80 ns period
        @(posedge clk);
        for (i = 0; i < 6; i++)
        begin
            const_rate_clock_hi <= 1'b1;
            const_rate_clock_lo <= 1'b1;
            repeat (5) @(posedge clk);
            const_rate_clock_hi <= 1'b0;
            const_rate_clock_lo <= 1'b0;
            repeat (5) @(posedge clk);
        end
        repeat (10) @(posedge clk);
        check("high slots", hi_cnt, 6);
        check("low slots", lo_cnt, 6);
        check("high first", order_bad, 0);
        header_check_error_n <= 1'b0;
        write_byte(1'b0, 8'h81);
        header_check_error_n <= 1'b1;
        @(posedge clk);
        reset_in <= 1'b1;
        #1;
        check("reset out async", reset_chain_out, 1);
        check("error reset", header_error, 0);
        repeat (2) @(posedge clk);
        reset_in <= 1'b0;
        repeat (4) @(posedge clk);
        read_byte(1'b1, 8'h00, "data after reset in");
        read_byte(1'b0, 8'h80, "status after reset in");
        report_and_stop();
    end
endmodule // test_manager_port_reset_and_command_pins
